//--- core/aogt_trim_regs.v
// Offset and fine gain trim register bank for a multi-core converter.
// Assumes a classic Wishbone master on clk_i, fuse defaults stable during
// reset, and a calibration engine that software waits on before access.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
`include "aogt_defs.vh"

module aogt_trim_regs (
    input  wire        clk_i,                 // Configuration clock, 200 MHz
    input  wire        rst_i,                 // Synchronous reset, active high
    input  wire        wb_cyc_i,              // Wishbone cycle
    input  wire        wb_stb_i,              // Wishbone strobe
    input  wire        wb_we_i,               // Wishbone write enable
    input  wire [31:0] wb_adr_i,              // Wishbone byte address
    input  wire [3:0]  wb_sel_i,              // Wishbone byte selects
    input  wire [31:0] wb_dat_i,              // Wishbone write data
    output reg  [31:0] wb_dat_o,              // Wishbone read data
    output wire        wb_ack_o,              // Wishbone acknowledge
    output wire        wb_err_o,              // Wishbone error, unmapped address
    input  wire [71:0] fuse_ofs_i,            // Fuse offsets, six 12-bit, core2a first
    input  wire [14:0] fuse_gain_i,           // Fuse gains, three 5-bit, core0 first
    output reg  [11:0] core2_offset_o,        // Offset applied to core 2
    output reg  [11:0] core3_offset_o,        // Offset applied to core 3
    output reg  [11:0] core4_offset_o,        // Offset applied to core 4
    output reg  [11:0] core5_offset_o,        // Offset applied to core 5
    output reg  [4:0]  core0_gain_o,          // Fine gain applied to core 0
    output reg  [4:0]  core1_gain_o,          // Fine gain applied to core 1
    output reg  [4:0]  core2a_gain_o,         // Fine gain for core 2 on pair A
    output reg         core2_on_pair_b_o,     // Core 2 samples pair B, else pair A
    output reg         core3_on_pair_d_o      // Core 3 samples pair D, else pair C
);

    // Register array: slots 0..5 offsets (16 bits), 6..8 gains (low 8 bits used)
    reg [15:0] trim [0:`AOGT_NREG-1];
    reg [1:0]  pair_sel;
    reg        ack_q;
    reg        err_q;
    reg        fuse_load;

    wire [`AOGT_AW-1:0] word_idx;
    wire                req;
    wire [3:0]          slot;

    // Map a register index to its storage slot; used by read and write paths
    function [3:0] aogt_slot;
        input [`AOGT_AW-1:0] idx;
        begin
            case (idx)
                `AOGT_IDX_OFFSET_2A: aogt_slot = `AOGT_SLOT_OFFSET_2A;
                `AOGT_IDX_OFFSET_2B: aogt_slot = `AOGT_SLOT_OFFSET_2B;
                `AOGT_IDX_OFFSET_3C: aogt_slot = `AOGT_SLOT_OFFSET_3C;
                `AOGT_IDX_OFFSET_3D: aogt_slot = `AOGT_SLOT_OFFSET_3D;
                `AOGT_IDX_OFFSET_4:  aogt_slot = `AOGT_SLOT_OFFSET_4;
                `AOGT_IDX_OFFSET_5:  aogt_slot = `AOGT_SLOT_OFFSET_5;
                `AOGT_IDX_GAIN_0:    aogt_slot = `AOGT_SLOT_GAIN_0;
                `AOGT_IDX_GAIN_1:    aogt_slot = `AOGT_SLOT_GAIN_1;
                `AOGT_IDX_GAIN_2A:   aogt_slot = `AOGT_SLOT_GAIN_2A;
                `AOGT_IDX_PAIRSEL: aogt_slot = `AOGT_SLOT_SEL;
                default:          aogt_slot = `AOGT_SLOT_NONE;
            endcase
        end
    endfunction

    // Address decode; a request is masked while its ack or err is showing
    assign word_idx = wb_adr_i[`AOGT_ADR_HI:`AOGT_ADR_LO];
    assign req      = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    assign slot     = aogt_slot(word_idx);
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    // One-cycle answer: ack or err registered one edge after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req & (slot != `AOGT_SLOT_NONE);
            err_q <= req & (slot == `AOGT_SLOT_NONE);
        end
    end

    // Fuse load runs on the first edge after reset release, since
    // the synchronous reset may only load constants
    always @(posedge clk_i) begin
        if (rst_i) begin
            fuse_load <= 1'b1;
        end else begin
            fuse_load <= 1'b0;
        end
    end

    // Offset registers: reset, fuse load, then byte-lane writes
    genvar g;
    generate
        for (g = 0; g < `AOGT_NUM_OFS; g = g + 1) begin : g_ofs
            always @(posedge clk_i) begin
                if (rst_i) begin
                    trim[g] <= `AOGT_OFS_RST;
                end else if (fuse_load) begin
                    trim[g] <= {4'h0, fuse_ofs_i[g*`AOGT_OFS_W +: `AOGT_OFS_W]};
                end else if (req & wb_we_i & (slot == g)) begin
                    if (wb_sel_i[0]) begin
                        trim[g][7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        trim[g][15:8] <= wb_dat_i[15:8];
                    end
                end
            end
        end
        for (g = 0; g < `AOGT_NUM_GAIN; g = g + 1) begin : g_gain
            always @(posedge clk_i) begin
                if (rst_i) begin
                    trim[`AOGT_NUM_OFS+g] <= {8'h00, `AOGT_GAIN_RST};
                end else if (fuse_load) begin
                    trim[`AOGT_NUM_OFS+g] <=
                        {11'h000, fuse_gain_i[g*`AOGT_GAIN_W +: `AOGT_GAIN_W]};
                end else if (req & wb_we_i & wb_sel_i[0] & (slot == `AOGT_NUM_OFS+g)) begin
                    // byte register keeps low lane only
                    trim[`AOGT_NUM_OFS+g] <= {8'h00, wb_dat_i[7:0]};
                end
            end
        end
    endgenerate

    // Pair selection register, a stand-in for the sampling mode control
    always @(posedge clk_i) begin
        if (rst_i) begin
            pair_sel <= `AOGT_SEL_RST;
        end else if (req & wb_we_i & wb_sel_i[0] & (slot == `AOGT_SLOT_SEL)) begin
            pair_sel <= wb_dat_i[1:0];
        end
    end

    // read mux, no side effects; reserved bits read as stored
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `AOGT_ZERO32;
        end else if (req & ~wb_we_i) begin
            if (slot == `AOGT_SLOT_SEL) begin
                wb_dat_o <= {30'h0, pair_sel};
            end else if (slot == `AOGT_SLOT_NONE) begin
                wb_dat_o <= `AOGT_ZERO32;
            end else begin
                wb_dat_o <= {16'h0000, trim[slot]};
            end
        end
    end

    // Trim values routed to the cores; registered so outputs settle cleanly
    always @(posedge clk_i) begin
        if (rst_i) begin
            core2_offset_o    <= 12'h000;
            core3_offset_o    <= 12'h000;
            core4_offset_o    <= 12'h000;
            core5_offset_o    <= 12'h000;
            core0_gain_o      <= 5'h00;
            core1_gain_o      <= 5'h00;
            core2a_gain_o     <= 5'h00;
            core2_on_pair_b_o <= 1'b0;
            core3_on_pair_d_o <= 1'b0;
        end else begin
            core2_offset_o <= pair_sel[`AOGT_SEL_CORE2_BIT] ?
                trim[`AOGT_SLOT_OFFSET_2B][`AOGT_OFS_MSB:0] :
                trim[`AOGT_SLOT_OFFSET_2A][`AOGT_OFS_MSB:0];
            core3_offset_o <= pair_sel[`AOGT_SEL_CORE3_BIT] ?
                trim[`AOGT_SLOT_OFFSET_3D][`AOGT_OFS_MSB:0] :
                trim[`AOGT_SLOT_OFFSET_3C][`AOGT_OFS_MSB:0];
            core4_offset_o <= trim[`AOGT_SLOT_OFFSET_4][`AOGT_OFS_MSB:0];
            core5_offset_o <= trim[`AOGT_SLOT_OFFSET_5][`AOGT_OFS_MSB:0];
            core0_gain_o <= trim[`AOGT_SLOT_GAIN_0][`AOGT_GAIN_MSB:0];
            core1_gain_o <= trim[`AOGT_SLOT_GAIN_1][`AOGT_GAIN_MSB:0];
            core2a_gain_o <= trim[`AOGT_SLOT_GAIN_2A][`AOGT_GAIN_MSB:0];
            core2_on_pair_b_o <= pair_sel[`AOGT_SEL_CORE2_BIT];
            core3_on_pair_d_o <= pair_sel[`AOGT_SEL_CORE3_BIT];
        end
    end

endmodule

//--- common/aogt_defs.vh
// Constants for the converter offset and fine gain trim register bank.
// Assumes a classic Wishbone slave with a 32-bit data bus, one word per register.
`ifndef AOGT_DEFS_VH
`define AOGT_DEFS_VH

// Printed register offsets are register indices; byte address is index times four
`define AOGT_IDX_OFFSET_2A  12'h334
`define AOGT_IDX_OFFSET_2B  12'h336
`define AOGT_IDX_OFFSET_3C  12'h338
`define AOGT_IDX_OFFSET_3D  12'h33a
`define AOGT_IDX_OFFSET_4   12'h33c
`define AOGT_IDX_OFFSET_5   12'h33e
`define AOGT_IDX_GAIN_0     12'h360
`define AOGT_IDX_GAIN_1     12'h361
`define AOGT_IDX_GAIN_2A    12'h362
// Own register: input pair selection for the shared cores
`define AOGT_IDX_PAIRSEL    12'h370

// Word address width (byte address bits 13:2)
`define AOGT_AW             12
`define AOGT_ADR_LO         2
`define AOGT_ADR_HI         13

// Field layouts
`define AOGT_OFS_W          12
`define AOGT_OFS_MSB        11
`define AOGT_OFS_RSV_MSB    15
`define AOGT_OFS_RSV_LSB    12
`define AOGT_GAIN_W         5
`define AOGT_GAIN_MSB       4
`define AOGT_GAIN_RSV_MSB   7
`define AOGT_GAIN_RSV_LSB   5
`define AOGT_SEL_CORE2_BIT  0
`define AOGT_SEL_CORE3_BIT  1

// Reset values (reserved bits default to zero)
`define AOGT_OFS_RST        16'h0000
`define AOGT_GAIN_RST       8'h00
`define AOGT_SEL_RST        2'h0
`define AOGT_ZERO32         32'h0000_0000

// Register count held in the array, and slot indices
`define AOGT_NREG           9
`define AOGT_SLOT_OFFSET_2A 4'h0
`define AOGT_SLOT_OFFSET_2B 4'h1
`define AOGT_SLOT_OFFSET_3C 4'h2
`define AOGT_SLOT_OFFSET_3D 4'h3
`define AOGT_SLOT_OFFSET_4  4'h4
`define AOGT_SLOT_OFFSET_5  4'h5
`define AOGT_SLOT_GAIN_0    4'h6
`define AOGT_SLOT_GAIN_1    4'h7
`define AOGT_SLOT_GAIN_2A   4'h8
`define AOGT_SLOT_SEL       4'h9
`define AOGT_SLOT_NONE      4'hf
`define AOGT_NUM_OFS        6
`define AOGT_NUM_GAIN       3

`endif

//--- testbench/aogt_trim_regs_checker.sv
// Bus timing and trim output checks for the trim register bank.
// Assumes the bench makes no request before two edges after reset.
`timescale 1ns/10ps
module aogt_trim_regs_checker (
    input wire        clk_i,             // Clock
    input wire        rst_i,             // Reset
    input wire        wb_cyc_i,          // Cycle
    input wire        wb_stb_i,          // Strobe
    input wire        wb_we_i,           // Write
    input wire [31:0] wb_adr_i,          // Address
    input wire [3:0]  wb_sel_i,          // Selects
    input wire [31:0] wb_dat_i,          // Write data
    input wire [31:0] wb_dat_o,          // Read data
    input wire        wb_ack_o,          // Ack
    input wire        wb_err_o,          // Error
    input wire [11:0] core4_offset_o,    // Core 4 offset
    input wire [4:0]  core0_gain_o,      // Core 0 gain
    input wire        core2_on_pair_b_o  // Core 2 pair
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A request is taken only while no answer is showing
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    sequence s_wr(a, m);
        req && wb_we_i && wb_adr_i == a && (wb_sel_i & m) == m;
    endsequence
    a_ack_after_req: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    a_err_reads_zero: assert property (wb_err_o && !$past(wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_core4_write: assert property (s_wr(32'hcf0, 4'h3) |=> ##1
        core4_offset_o == $past(wb_dat_i[11:0], 2))
        else $error("core 4 offset not applied");
    a_fine_gain_core0_write: assert property (s_wr(32'hd80, 4'h1) |=> ##1
        core0_gain_o == $past(wb_dat_i[4:0], 2))
        else $error("core 0 gain not applied");
    a_pair_b_flag: assert property (s_wr(32'hdc0, 4'h1) |=> ##1
        core2_on_pair_b_o == $past(wb_dat_i[0], 2))
        else $error("core 2 pair flag wrong");
    // Fuse values reach the outputs two edges after release, so skip that window
    a_idle_holds: assert property ((!wb_cyc_i [*3] ##0 !$past(rst_i, 3)) |=>
        $stable(core4_offset_o) && $stable(core0_gain_o))
        else $error("trim changed while idle");
endmodule
bind aogt_trim_regs aogt_trim_regs_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .core4_offset_o(core4_offset_o), .core0_gain_o(core0_gain_o),
    .core2_on_pair_b_o(core2_on_pair_b_o));

//--- testbench/tb_aogt_trim_regs.sv
// Self-checking bench for the trim register bank over classic Wishbone.
// Assumes fixed fuse patterns and the bound checker beside the design.
`timescale 1ns/10ps
`include "aogt_defs.vh"
module tb_aogt_trim_regs;
    reg         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    reg  [31:0] adr = 32'h0, wdat = 32'h0, rd;
    reg  [3:0]  sel = 4'h0;
    reg  [71:0] fofs = {12'h6f6, 12'h5e5, 12'h4d4, 12'h3c3, 12'h2b2, 12'h1a1};
    reg  [14:0] fgain = {5'h13, 5'h0a, 5'h15};
    reg  [31:0] exp_q [0:8];
    reg  [11:0] idx [0:8];
    reg         rerr;
    wire [31:0] rdat;
    wire        ack, err, pb, pd;
    wire [11:0] c2o, c3o, c4o, c5o;
    wire [4:0]  g0, g1, g2a;
    integer     n_errors = 0, num_checks = 0, i, j, p;
    aogt_trim_regs i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .fuse_ofs_i(fofs), .fuse_gain_i(fgain), .core2_offset_o(c2o),
        .core3_offset_o(c3o), .core4_offset_o(c4o), .core5_offset_o(c5o),
        .core0_gain_o(g0), .core1_gain_o(g1), .core2a_gain_o(g2a),
        .core2_on_pair_b_o(pb), .core3_on_pair_d_o(pd));
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    task check(input [31:0] seen, input [31:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want) begin
                n_errors = n_errors + 1;
                $display("BAD %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask
    // One classic cycle; a spare edge after release keeps cyc low a cycle
    task bus(input w, input [11:0] x, input [31:0] d, input [3:0] s);
        integer k;
        begin
            k = 0;
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= {18'h0, x, 2'h0};
            wdat <= d;
            sel <= s;
            @(posedge clk_i);
            while (ack !== 1'b1 && err !== 1'b1 && k < 20) begin
                @(posedge clk_i);
                k = k + 1;
            end
            if (k == 20)
                n_errors = n_errors + 1;
            rd = rdat;
            rerr = err;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task read_all;
        for (j = 0; j < 9; j = j + 1) begin
            bus(1'b0, idx[j], 32'h0, 4'hf);
            check(rd, exp_q[j]);
        end
    endtask
    task cores(input b, input d);
        begin
            check({20'h0, c2o}, b ? exp_q[1] : exp_q[0]);
            check({20'h0, c3o}, d ? exp_q[3] : exp_q[2]);
            check({20'h0, c4o}, exp_q[4]);
            check({20'h0, c5o}, exp_q[5]);
            check({27'h0, g0}, exp_q[6]);
            check({27'h0, g1}, exp_q[7]);
            check({27'h0, g2a}, exp_q[8]);
            check({30'h0, pd, pb}, {30'h0, d, b});
        end
    endtask
    task t_fuse;
        begin
            for (i = 0; i < 9; i = i + 1)
                exp_q[i] = (i < 6) ? fofs[i*12 +: 12] : fgain[(i-6)*5 +: 5];
            read_all;
            cores(1'b0, 1'b0);
            $display("fuse defaults done");
        end
    endtask
    // Full-scale offset first: offsets are unsigned, reserved bits written zero
    task t_write;
        begin
            for (i = 0; i < 9; i = i + 1) begin
                exp_q[i] = (i < 6) ? 32'h0fff - i * 32'h123 : 32'h1f - i;
                bus(1'b1, idx[i], exp_q[i], 4'hf);
            end
            read_all;
            cores(1'b0, 1'b0);
            $display("write and apply done");
        end
    endtask
    task t_pair;
        begin
            for (p = 0; p < 4; p = p + 1) begin
                bus(1'b1, `AOGT_IDX_PAIRSEL, {30'h0, p[1:0]}, 4'h1);
                cores(p[0], p[1]);
            end
            bus(1'b1, `AOGT_IDX_PAIRSEL, 32'h0, 4'h1);
            $display("pair select done");
        end
    endtask
    // Unmapped reads and writes must neither answer data nor touch trims
    task t_bad;
        begin
            bus(1'b0, 12'h000, 32'h0, 4'hf);
            check({31'h0, rerr}, 32'h1);
            check(rd, 32'h0);
            bus(1'b1, 12'h335, 32'h0abc, 4'hf);
            check({31'h0, rerr}, 32'h1);
            read_all;
            $display("unmapped access done");
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Main sequence
    // no calibration engine runs here, so offset access needs no wait
    initial begin
        for (i = 0; i < 9; i = i + 1)
            idx[i] = (i < 6) ? `AOGT_IDX_OFFSET_2A + 12'h002 * i[11:0]
                             : `AOGT_IDX_GAIN_0 + i[11:0] - 12'h006;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_fuse;
        t_write;
        t_pair;
        t_bad;
        results;
    end
    // Watchdog, far beyond the 150 or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors = n_errors + 1;
        results;
    end
endmodule
